// file: common/ees_pkg.sv
// Constants, field positions, timing counts and carrier types of the serial eeprom slave.
// Assumes a single 200 MHz system clock; the serial clock is a sampled input.
// How it works
// RULE1 - below the supply threshold (reset held) no instruction is answered; afterwards standby.
// RULE2 - once supply drops below threshold (reset asserted) responding stops at once.
// RULE3 - master leaves device in standby, after Stop, with no write cycle running.
// RULE4 - Start is SDA falling while SCL high; precedes every command.
// RULE5 - Start is watched at all times except during the internal write cycle.
// RULE6 - Stop is SDA rising while SCL high; it ends the current exchange.
// RULE7 - read ended by master no-acknowledge then Stop returns device to standby.
// RULE8 - transmitter releases SDA after eight bits; receiver pulls it low on ninth.
// RULE9 - received SDA level is captured at every SCL rising edge.
// RULE10 - master changes SDA only while SCL low, except Start and Stop.
// RULE11 - select byte travels most significant bit first, b7 leading.
// RULE12 - select byte: type id b7..b4, chip enables b3..b1, direction b0.
// RULE13 - respond only when received chip-enable field equals the three chip-enable pins.
// RULE14 - direction bit one means read, zero means write.
// RULE15 - match gets acknowledge in ninth slot; mismatch releases bus, back to standby.
// RULE16 - after write select: acknowledge, take two address bytes acknowledging each, then data.
// RULE17 - address is 16 bits: high byte first, then low byte.
// RULE18 - protect input high from Start to second address byte end guards top quarter.
// RULE19 - write cycle starts only on Stop in tenth slot after a data acknowledge.
// RULE20 - during write cycle SDA stays released and every request is ignored.
// RULE21 - byte write is one data byte then Stop; protected location stays unchanged.
// RULE22 - sequential read returns one or more consecutive bytes.
// RULE23 - array holds 8192 bytes; sets address range and protected quarter.
// RULE24 - unconnected chip-enable and protect inputs read low, writes allowed.
// RULE25 - during writes only the five low address bits advance, wrapping in a row.
// RULE26 - address bits b15..b13 ignored; protected quarter has b12 and b11 set.
// RULE27 - data for a protected range is acknowledged but discarded.
package ees_pkg;

    // ****************************************************************
    // geometry and timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 5;
    localparam int ADDR_W = 13;
    localparam int MEM_DEPTH = 8192;
    localparam int PAGE_W = 5;
    localparam int PAGE_BYTES = 32;
    localparam int WRITE_TIME_NS = 5000000; // default internal_write_duration

    // ****************************************************************
    // bit slots and field positions
    // ****************************************************************
    localparam logic [3:0] LAST_DATA_BIT = 4'h7;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam int TYPE_MSB = 7;
    localparam int TYPE_LSB = 4;
    localparam int CE_MSB = 3;
    localparam int CE_LSB = 1;
    localparam int DIR_BIT = 0;
    localparam logic [1:0] PROT_QUARTER = 2'h3;
    localparam logic [3:0] DEV_TYPE_ID = 4'h5; // arbitrary value

    typedef enum {
        PH_IDLE,
        PH_SEL,
        PH_AHI,
        PH_ALO,
        PH_WDATA,
        PH_RDATA,
        PH_BUSY
    } ees_phase_t;

    // strap-like pins sampled together
    typedef struct packed {
        logic wp;
        logic [2:0] ce;
    } ees_pins_t;

    // visible status of the device
    typedef struct packed {
        logic busy;
        logic selected;
    } ees_status_t;

endpackage : ees_pkg

// file: rtl/ees_slave.sv
// Two-wire serial eeprom slave: select decode, addressing, page latches, array, write timer.
// Assumes scl/sda and pins arrive asynchronously; rst_n is the supply-good reset.
module ees_slave
    import ees_pkg::*;
#(
    parameter int WRITE_TIME = WRITE_TIME_NS,
    parameter logic [3:0] TYPE_ID = DEV_TYPE_ID // arbitrary value
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic chip_sel_pin0,
    input wire logic chip_sel_pin1,
    input wire logic chip_sel_pin2,
    input wire logic write_protect_input,
    output ees_status_t status
);

    localparam int WRITE_CYCLES = WRITE_TIME / CLK_PERIOD_NS;
    // the clock fall that closes a start is no bit slot: the count wraps to zero there
    localparam logic [3:0] PRE_SLOT = 4'hF;

    // ****************************************************************
    // elaboration checks
    // ****************************************************************
    if (WRITE_CYCLES < 1) begin : g_bad_time
        $error("write time shorter than one clock");
    end
    if (MEM_DEPTH != (1 << ADDR_W) || PAGE_BYTES != (1 << PAGE_W)) begin : g_bad_geom
        $error("array or page size inconsistent with address width");
    end

    // ****************************************************************
    // input synchronisers
    // ****************************************************************
    logic scl_m, scl_s, scl_q;
    logic sda_m, sda_s, sda_q;
    ees_pins_t pins_m, pins;

    // two flops per input, third stage only for edge finding
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            scl_q <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_q <= 1'b1;
            pins_m <= '0; // RULE24
            pins <= '0;
        end else begin
            scl_m <= scl_in;
            scl_s <= scl_m;
            scl_q <= scl_s;
            sda_m <= sda_in;
            sda_s <= sda_m;
            sda_q <= sda_s;
            pins_m <= {write_protect_input, chip_sel_pin2, chip_sel_pin1, chip_sel_pin0};
            pins <= pins_m;
        end
    end

    // ****************************************************************
    // bus events
    // ****************************************************************
    logic scl_rise, scl_fall, start_det, stop_det;

    // start and stop only while scl stays high across both samples
    assign scl_rise = scl_s & ~scl_q; // RULE9
    assign scl_fall = ~scl_s & scl_q;
    assign start_det = scl_s & scl_q & sda_q & ~sda_s; // RULE4
    assign stop_det = scl_s & scl_q & ~sda_q & sda_s; // RULE6

    // ****************************************************************
    // protocol engine
    // ****************************************************************
    ees_phase_t phase;
    logic [3:0] bit_cnt;
    logic [7:0] sr;
    logic [7:0] tx;
    logic [ADDR_W-1:0] addr;
    logic rw, wp_seen, nack, sel_match;
    logic [PAGE_W:0] data_cnt;
    logic [31:0] wr_cnt;
    logic [7:0] mem [MEM_DEPTH];
    logic [7:0] rd_byte;
    logic prot, store_en, commit, wr_trigger;
    logic [PAGE_BYTES-1:0] page_valid;
    logic [7:0] page_data [PAGE_BYTES];

    assign rd_byte = mem[addr];
    // upper address bits above the array are dropped on load
    assign prot = wp_seen && (addr[ADDR_W-1:ADDR_W-2] == PROT_QUARTER); // RULE26
    assign sel_match = (sr[TYPE_MSB:TYPE_LSB] == TYPE_ID) // RULE12
        && (sr[CE_MSB:CE_LSB] == pins.ce); // RULE13
    assign store_en = scl_fall && phase == PH_WDATA && bit_cnt == LAST_DATA_BIT && !prot;
    assign commit = phase == PH_BUSY && wr_cnt == 32'h00000001;
    assign wr_trigger = stop_det && phase == PH_WDATA && bit_cnt == 4'h0 && data_cnt != '0;
    assign sda_out = 1'b0; // open drain: only the enable moves
    assign status.busy = phase == PH_BUSY;
    assign status.selected = phase != PH_IDLE && phase != PH_BUSY;

    // main sequencer: phase, bit slot, shifting, address, sda enable
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            phase <= PH_IDLE; // RULE1 RULE2
            bit_cnt <= 4'h0;
            sr <= 8'h00;
            tx <= 8'h00;
            addr <= '0;
            rw <= 1'b0;
            wp_seen <= 1'b0;
            nack <= 1'b0;
            data_cnt <= '0;
            wr_cnt <= 32'h00000000;
            sda_oe <= 1'b0;
        end else if (phase == PH_BUSY) begin
            // bus is deaf and released while the array is programmed
            sda_oe <= 1'b0; // RULE20
            wr_cnt <= wr_cnt - 32'h00000001;
            if (wr_cnt == 32'h00000001) begin
                phase <= PH_IDLE;
            end
        end else if (start_det) begin
            phase <= PH_SEL; // RULE5
            bit_cnt <= PRE_SLOT;
            sda_oe <= 1'b0;
            wp_seen <= pins.wp; // RULE18
            data_cnt <= '0;
        end else if (stop_det) begin
            sda_oe <= 1'b0;
            if (wr_trigger) begin
                phase <= PH_BUSY; // RULE19
                wr_cnt <= WRITE_CYCLES[31:0];
            end else begin
                phase <= PH_IDLE; // RULE6 RULE7
            end
        end else if (phase != PH_IDLE) begin
            if (phase == PH_SEL || phase == PH_AHI || phase == PH_ALO) begin
                wp_seen <= wp_seen | pins.wp; // RULE18
            end
            if (scl_rise) begin
                if (bit_cnt < ACK_SLOT) begin
                    sr <= {sr[6:0], sda_s}; // RULE9 RULE11
                end else begin
                    nack <= sda_s; // master ack sample in read
                end
            end
            if (scl_fall) begin
                if (bit_cnt == LAST_DATA_BIT) begin
                    bit_cnt <= ACK_SLOT;
                    case (phase)
                        PH_SEL: begin
                            if (sel_match) begin
                                sda_oe <= 1'b1; // RULE15 RULE8
                                rw <= sr[DIR_BIT]; // RULE14
                            end else begin
                                phase <= PH_IDLE; // RULE13 RULE15
                            end
                        end
                        PH_AHI: begin
                            addr[ADDR_W-1:8] <= sr[ADDR_W-9:0]; // RULE17 RULE26
                            sda_oe <= 1'b1; // RULE16
                        end
                        PH_ALO: begin
                            addr[7:0] <= sr; // RULE17
                            sda_oe <= 1'b1; // RULE16
                        end
                        PH_WDATA: begin
                            sda_oe <= 1'b1; // RULE27
                            addr[PAGE_W-1:0] <= addr[PAGE_W-1:0] + 5'h01; // RULE25
                            data_cnt <= data_cnt + 6'h01;
                        end
                        PH_RDATA: begin
                            sda_oe <= 1'b0; // RULE8
                            addr <= addr + 13'h0001; // RULE22
                        end
                        default: begin
                            sda_oe <= 1'b0;
                        end
                    endcase
                end else if (bit_cnt == ACK_SLOT) begin
                    bit_cnt <= 4'h0;
                    sda_oe <= 1'b0;
                    case (phase)
                        PH_SEL: begin
                            if (rw) begin
                                phase <= PH_RDATA;
                                tx <= rd_byte;
                                sda_oe <= ~rd_byte[7];
                            end else begin
                                phase <= PH_AHI; // RULE16
                            end
                        end
                        PH_AHI: phase <= PH_ALO;
                        PH_ALO: phase <= PH_WDATA;
                        PH_RDATA: begin
                            if (nack) begin
                                phase <= PH_IDLE; // RULE7
                            end else begin
                                tx <= rd_byte; // RULE22
                                sda_oe <= ~rd_byte[7];
                            end
                        end
                        default: phase <= phase;
                    endcase
                end else begin
                    bit_cnt <= bit_cnt + 4'h1;
                    if (phase == PH_RDATA) begin
                        tx <= {tx[6:0], 1'b0};
                        sda_oe <= ~tx[6];
                    end
                end
            end
        end
    end

    // ****************************************************************
    // page latches
    // ****************************************************************
    for (genvar i = 0; i < PAGE_BYTES; i++) begin : g_page
        // each latch takes the byte aimed at its column, cleared by start or commit
        always_ff @(posedge sys_clk) begin
            if (!rst_n) begin
                page_valid[i] <= 1'b0;
                page_data[i] <= 8'h00;
            end else if (commit || (start_det && phase != PH_BUSY)) begin
                page_valid[i] <= 1'b0;
            end else if (store_en && addr[PAGE_W-1:0] == PAGE_W'(i)) begin
                page_valid[i] <= 1'b1; // RULE21 RULE27
                page_data[i] <= sr;
            end
        end
    end

    // ****************************************************************
    // array
    // ****************************************************************
    // valid latches are programmed into the current row at cycle end
    always_ff @(posedge sys_clk) begin
        if (commit) begin
            for (int j = 0; j < PAGE_BYTES; j++) begin
                if (page_valid[j]) begin
                    mem[{addr[ADDR_W-1:PAGE_W], j[PAGE_W-1:0]}] <= page_data[j]; // RULE23
                end
            end
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    logic [PAGE_W-1:0] addr_col;
    logic [ADDR_W-PAGE_W-1:0] addr_row;
    assign addr_col = addr[PAGE_W-1:0];
    assign addr_row = addr[ADDR_W-1:PAGE_W];

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    property p_reset_quiet;
        $rose(rst_n) |-> !sda_oe && phase == PH_IDLE;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("not quiet after reset"); // RULE1

    property p_start_sel;
        start_det && phase != PH_BUSY |=> phase == PH_SEL && bit_cnt == PRE_SLOT && !sda_oe;
    endproperty
    a_start_sel: assert property (p_start_sel) else $error("start not taken"); // RULE5

    property p_busy_silent;
        phase == PH_BUSY |=> !sda_oe;
    endproperty
    a_busy_silent: assert property (p_busy_silent) else $error("sda driven while busy"); // RULE20

    property p_busy_deaf;
        phase == PH_BUSY && wr_cnt > 32'h00000001 && start_det |=> phase == PH_BUSY;
    endproperty
    a_busy_deaf: assert property (p_busy_deaf) else $error("start taken while busy"); // RULE20

    property p_stop_idle;
        stop_det && phase != PH_BUSY && !wr_trigger |=> phase == PH_IDLE ##1 !sda_oe;
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("stop did not end exchange"); // RULE6

    property p_mismatch;
        scl_fall && phase == PH_SEL && bit_cnt == LAST_DATA_BIT && !sel_match
            |=> phase == PH_IDLE && !sda_oe;
    endproperty
    a_mismatch: assert property (p_mismatch) else $error("mismatch not released"); // RULE15

    property p_match_ack;
        scl_fall && phase == PH_SEL && bit_cnt == LAST_DATA_BIT && sel_match
            |=> sda_oe && bit_cnt == ACK_SLOT;
    endproperty
    a_match_ack: assert property (p_match_ack) else $error("match not acknowledged"); // RULE8

    property p_trigger;
        wr_trigger |=> phase == PH_BUSY && wr_cnt == WRITE_CYCLES[31:0];
    endproperty
    a_trigger: assert property (p_trigger) else $error("write cycle not started"); // RULE19

    property p_busy_end;
        commit |=> phase == PH_IDLE && page_valid == '0;
    endproperty
    a_busy_end: assert property (p_busy_end) else $error("write cycle end wrong"); // RULE20

    property p_protect;
        scl_fall && phase == PH_WDATA && bit_cnt == LAST_DATA_BIT && prot
            |=> $stable(page_valid) && sda_oe;
    endproperty
    a_protect: assert property (p_protect) else $error("protected byte latched"); // RULE27

    property p_sample;
        scl_rise && phase == PH_SEL && bit_cnt < ACK_SLOT && !start_det && !stop_det
            |=> sr[0] == $past(sda_s);
    endproperty
    a_sample: assert property (p_sample) else $error("bit not captured"); // RULE9

    property p_col_wrap;
        store_en && !start_det && !stop_det
            |=> addr_row == $past(addr_row) && addr_col == $past(addr_col) + 5'h01;
    endproperty
    a_col_wrap: assert property (p_col_wrap) else $error("address advance wrong"); // RULE25

    property p_ack_release;
        scl_fall && bit_cnt == ACK_SLOT && (phase == PH_AHI || phase == PH_ALO
            || phase == PH_WDATA || (phase == PH_SEL && !rw)) |=> !sda_oe;
    endproperty
    a_ack_release: assert property (p_ack_release) else $error("ack held too long"); // RULE8

    property p_read_release;
        scl_fall && phase == PH_RDATA && bit_cnt == LAST_DATA_BIT
            |=> !sda_oe && bit_cnt == ACK_SLOT;
    endproperty
    a_read_release: assert property (p_read_release) else $error("read ack slot driven"); // RULE8

    property p_nack_idle;
        scl_fall && phase == PH_RDATA && bit_cnt == ACK_SLOT && nack
            |=> phase == PH_IDLE && !sda_oe;
    endproperty
    a_nack_idle: assert property (p_nack_idle) else $error("no standby after nack"); // RULE7

endmodule : ees_slave

// file: test/ees_mst_model.sv
// Behavioural two-wire bus master: drives the serial clock and pulls the data wire low.
// Assumes a pull-up resolves the data wire; paced by falling edges of the 200 MHz clock.
module ees_mst_model (
    input wire logic sys_clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda_low
);
    timeunit 1ns;
    timeprecision 1ps;

    // bus idle: clock high, data released
    initial begin
        scl = 1'h1;
        sda_low = 1'h0;
    end

    // ****************************************************************
    // bus tasks
    // ****************************************************************
    task automatic wait_c(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : wait_c

    // start: data falls while clock high, also usable as repeated start
    task automatic start();
        wait_c(4);
        sda_low = 1'h0;
        wait_c(4);
        scl = 1'h1;
        wait_c(8);
        sda_low = 1'h1;
        wait_c(8);
        scl = 1'h0;
    endtask : start

    // stop: data rises while clock high, leaving the device in standby, or starting its write cycle after written data
    task automatic stop();
        wait_c(4);
        sda_low = 1'h1;
        wait_c(4);
        scl = 1'h1;
        wait_c(8);
        sda_low = 1'h0;
        wait_c(8);
    endtask : stop

    // one clock pulse; data only moves while the clock is low
    task automatic bit_x(input logic b, output logic r);
        wait_c(4);
        sda_low = ~b;
        wait_c(4);
        scl = 1'h1;
        wait_c(4);
        r = sda_line;
        wait_c(4);
        scl = 1'h0;
    endtask : bit_x

    // byte out msb first, then release the wire for the acknowledge
    task automatic byte_w(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], r);
        end
        bit_x(1'h1, ack);
    endtask : byte_w

    // byte in msb first, then acknowledge low or leave released
    task automatic byte_r(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'h1, d[i]);
        end
        bit_x(nack, r);
    endtask : byte_r
endmodule : ees_mst_model

// file: test/ees_slave_tb_top.sv
// Self-checking bench of the serial eeprom slave with a behavioural bus master.
// Assumes the write timer is shortened to 400 cycles; the data wire has a pull-up.
module ees_slave_tb_top import ees_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic sys_clk = 1'h0;
    logic rst_n = 1'h0;
    ees_pins_t pins = '{wp: 1'h0, ce: 3'h6};
    logic sda_out, sda_oe, scl, sda_low;
    ees_status_t status;
    int n_errors = 0;
    int checks = 0;
    // open-drain wire: either party pulls low, otherwise the pull-up wins
    wire logic sda_line = ~((sda_oe & ~sda_out) | sda_low);

    // 200 MHz system clock
    always #2.5 sys_clk = ~sys_clk;

    ees_slave #(.WRITE_TIME(2000)) DUT (.sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .chip_sel_pin0(pins.ce[0]),
        .chip_sel_pin1(pins.ce[1]), .chip_sel_pin2(pins.ce[2]),
        .write_protect_input(pins.wp), .status(status));
    ees_mst_model MST (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));

    // ****************************************************************
    // checking and bus helpers
    // ****************************************************************
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t byte %h expected %h", $time, got, exp);
        end
    endtask : chk_byte

    task automatic chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t bit %b expected %b", $time, got, exp);
        end
    endtask : chk_bit

    // select byte; ack is the wire level in the ninth slot, low means taken
    task automatic sel(input logic rw, input logic [2:0] ce, input logic exp_ack);
        logic a;
        MST.byte_w({DEV_TYPE_ID, ce, rw}, a);
        chk_bit(a, exp_ack);
    endtask : sel

    task automatic set_addr(input logic [15:0] a);
        logic k;
        MST.start();
        sel(1'h0, pins.ce, 1'h0);
        MST.byte_w(a[15:8], k);
        chk_bit(k, 1'h0);
        MST.byte_w(a[7:0], k);
        chk_bit(k, 1'h0);
    endtask : set_addr

    task automatic wr(input logic [15:0] a, input int n, input logic [7:0] d [3]);
        logic k;
        set_addr(a);
        for (int i = 0; i < n; i++) begin
            MST.byte_w(d[i], k);
            chk_bit(k, 1'h0);
        end
        MST.stop();
    endtask : wr

    task automatic rd(input logic [15:0] a, input int n, input logic [7:0] e [3]);
        logic [7:0] d;
        set_addr(a);
        MST.start();
        sel(1'h1, pins.ce, 1'h0);
        for (int i = 0; i < n; i++) begin
            MST.byte_r(i == n - 1, d);
            chk_byte(d, e[i]);
        end
        MST.stop();
        chk_bit(status.selected, 1'h0);
    endtask : rd

    // bounded wait for the write cycle to finish
    task automatic wait_idle();
        for (int i = 0; i < 1000 && status.busy !== 1'h0; i++) @(negedge sys_clk);
        if (status.busy !== 1'h0) begin
            n_errors++;
            $display("[ERR] %0t write cycle never ended", $time);
            give_verdict();
        end
    endtask : wait_idle

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset();
        repeat (20) @(negedge sys_clk);
        chk_bit(sda_oe, 1'h0);
        chk_bit(status.busy, 1'h0);
        rst_n = 1'h1;
        repeat (4) @(negedge sys_clk);
        chk_bit(status.selected, 1'h0);
        $display("reset test done");
    endtask : t_reset

    task automatic t_bad_sel();
        MST.start();
        sel(1'h0, 3'h3, 1'h1);
        sel(1'h0, pins.ce, 1'h1);
        MST.stop();
        chk_bit(status.selected, 1'h0);
        $display("select mismatch test done");
    endtask : t_bad_sel

    task automatic t_page();
        wr(16'h001E, 3, '{8'h11, 8'h22, 8'h33});
        chk_bit(status.busy, 1'h1);
        MST.start();
        sel(1'h0, pins.ce, 1'h1);
        MST.stop();
        wait_idle();
        rd(16'h001E, 2, '{8'h11, 8'h22, 8'h00});
        rd(16'h0000, 1, '{8'h33, 8'h00, 8'h00});
        $display("page write test done");
    endtask : t_page

    task automatic t_no_trig();
        set_addr(16'h0040);
        MST.stop();
        chk_bit(status.busy, 1'h0);
        $display("stop slot test done");
    endtask : t_no_trig

    task automatic t_protect();
        wr(16'h1800, 1, '{8'h3C, 8'h00, 8'h00});
        wait_idle();
        pins.wp = 1'h1;
        wr(16'hF800, 1, '{8'hC3, 8'h00, 8'h00});
        wait_idle();
        pins.wp = 1'h0;
        rd(16'h1800, 1, '{8'h3C, 8'h00, 8'h00});
        $display("write protect test done");
    endtask : t_protect

    task automatic t_power();
        MST.start();
        sel(1'h0, pins.ce, 1'h0);
        rst_n = 1'h0;
        repeat (2) @(negedge sys_clk);
        chk_bit(status.selected, 1'h0);
        chk_bit(sda_oe, 1'h0);
        MST.stop();
        MST.start();
        sel(1'h0, pins.ce, 1'h1);
        MST.stop();
        rst_n = 1'h1;
        repeat (4) @(negedge sys_clk);
        rd(16'h0000, 1, '{8'h33, 8'h00, 8'h00});
        $display("power cycle test done");
    endtask : t_power

    // main sequence
    initial begin
        t_reset();
        t_bad_sel();
        t_page();
        t_no_trig();
        t_protect();
        t_power();
        give_verdict();
    end
endmodule : ees_slave_tb_top
